// ===== rtl/output_compare_channel.sv
// Purpose: one output compare channel, dual compare and PWM modes
// Assumes: timers share clk; APB slave, zero wait states
// Notes: fault input is synchronised, shutdown lags it by three clocks
//
// Behaviour
// - primary zero, first period stays low
// - primary zero, period equals secondary: one-cycle low
// - falling secondary match sets channel flag
// - primary >= secondary: rise, period reset, fall
// - secondary beyond period: single rise, no flag
// - all zero still pulses, two clocks late
// - primary beyond period keeps output low
// - codes 110/111 select PWM, 111 adds fault
// - fault low shuts PWM output down
// - PWM primary is read-only working duty
// - period match copies secondary into primary
// - PWM period match pulses timer flag
// - primary seeded before enable sets first duty
// - PWM high at period, low at duty
// - code 101 is continuous dual compare
// - fault floats output, sets channel flag
// - fault status bit four, sticky until rewrite
// - duty zero low, duty beyond period high
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/100ps
`include "ocmp_regs.svh"
module output_compare_channel (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input ocmp_pkg::timer_type timerA,
    input ocmp_pkg::timer_type timerB,
    input wire logic faultIn_n,
    output logic compareOut,
    output logic compareOutEn,
    output logic channelFlagPulse,
    output logic timerFlagPulse
);
    logic [2:0] mode_q;
    logic timeBaseSel_q;
    logic [15:0] primary_q;
    logic [15:0] secondary_q;
    logic chFlag_q;
    logic tmFlag_q;
    logic fault_q;
    logic outLevel_q;
    logic [15:0] prevCount_q;
    logic prevMatch_q;
    logic faultSync_n;
    ocmp_pkg::timer_type tb;
    ocmp_pkg::mode_type mode;
    logic setupPhase;
    logic wrEn;
    logic addrOk;
    logic wrCtrl;
    logic wrPri;
    logic wrSec;
    logic wrFlags;
    logic pwmMode;
    logic dualMode;
    logic countEvent;
    logic priMatch;
    logic secMatch;
    logic riseDual;
    logic fallDual;
    logic faultNow;
    logic loadDuty;
    logic [15:0] nextDuty;
    logic [31:0] readData;

    assign mode = ocmp_pkg::mode_type'(mode_q);

    time_base_select tbSel (
        .timerA(timerA),
        .timerB(timerB),
        .selectB(timeBaseSel_q),
        .selected(tb)
    );

    // fault pin comes from outside, two flops before use
    bit_sync faultSync (
        .clk(clk),
        .rst_n(rst_n),
        .resetValue(1'b1),
        .asyncIn(faultIn_n),
        .syncOut(faultSync_n)
    );

    // apb decode, slave never inserts wait states
    assign pready = 1'b1;
    assign setupPhase = psel && !penable;
    assign wrEn = psel && penable && pwrite;
    assign addrOk = (paddr == `OCMP_CTRL_OFFSET) ||
                    (paddr == `OCMP_PRI_OFFSET) ||
                    (paddr == `OCMP_SEC_OFFSET) ||
                    (paddr == `OCMP_FLAGS_OFFSET);
    assign pslverr = psel && penable && !addrOk;
    assign wrCtrl = wrEn && (paddr == `OCMP_CTRL_OFFSET);
    assign wrPri = wrEn && (paddr == `OCMP_PRI_OFFSET);
    assign wrSec = wrEn && (paddr == `OCMP_SEC_OFFSET);
    assign wrFlags = wrEn && (paddr == `OCMP_FLAGS_OFFSET);

    assign pwmMode = (mode == ocmp_pkg::MODE_PWM) ||
                     (mode == ocmp_pkg::MODE_PWM_FLT);
    assign dualMode = (mode == ocmp_pkg::MODE_DUAL);

    // a compare only counts when the timer has moved or had a period match the clock before, so a timer
    // parked at zero at enable time cannot match a zero primary
    // no match before moving or a period match
    assign countEvent = (tb.count != prevCount_q) || prevMatch_q;
    assign priMatch = countEvent && (tb.count == primary_q);
    assign secMatch = countEvent && (tb.count == secondary_q);

    // equal compares toggle so the all-zero case still pulses
    // coincident matches alternate
    assign riseDual = dualMode && priMatch && !outLevel_q;
    assign fallDual = dualMode && secMatch && outLevel_q &&
                      !(priMatch && !outLevel_q);

    assign faultNow = (mode == ocmp_pkg::MODE_PWM_FLT) && !faultSync_n;

    assign loadDuty = pwmMode && tb.periodMatch;
    assign nextDuty = secondary_q;

    // history of the selected timer for movement detection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prevCount_q <= 16'h0000;
            prevMatch_q <= 1'b0;
        end else begin
            prevCount_q <= tb.count;
            prevMatch_q <= tb.periodMatch;
        end
    end

    // control register: mode and time base select
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= `OCMP_CTRL_RESET;
            timeBaseSel_q <= 1'b0;
        end else if (wrCtrl) begin
            mode_q <= pwdata[`OCMP_MODE_MSB:`OCMP_MODE_LSB];
            timeBaseSel_q <= pwdata[`OCMP_TBSEL_BIT];
        end
    end

    // primary compare, software-owned outside PWM
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            primary_q <= `OCMP_PRI_RESET;
        end else if (loadDuty) begin
            primary_q <= nextDuty;
        end else if (wrPri && !pwmMode) begin
            primary_q <= pwdata[15:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            secondary_q <= `OCMP_SEC_RESET;
        end else if (wrSec) begin
            secondary_q <= pwdata[15:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_q <= 1'b0;
        end else if (faultNow) begin
            fault_q <= 1'b1;
        end else if (wrCtrl && pwdata[`OCMP_MODE_MSB:`OCMP_MODE_LSB + 1] ==
                     2'h3) begin
            // cleared only by a PWM rewrite with the pin released
            fault_q <= 1'b0;
        end
    end

    // output level: one process owns every mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            outLevel_q <= 1'b0;
        end else if (wrCtrl) begin
            if (pwdata[`OCMP_MODE_MSB:`OCMP_MODE_LSB + 1] == 2'h3) begin
                outLevel_q <= (primary_q != 16'h0000);
            end else begin
                outLevel_q <= 1'b0;
            end
        end else if (pwmMode) begin
            if (tb.periodMatch) begin
                // high at period, zero duty stays low
                outLevel_q <= (nextDuty != 16'h0000);
            end else if (tb.count == primary_q) begin
                outLevel_q <= 1'b0;
            end
        end else if (riseDual) begin
            // rise one clock after primary match
            outLevel_q <= 1'b1;
        end else if (fallDual) begin
            outLevel_q <= 1'b0;
        end else if (!dualMode) begin
            outLevel_q <= 1'b0;
        end
    end

    // pin data and enable come from flops
    assign compareOut = outLevel_q;
    assign compareOutEn = !fault_q;

    // event pulses for the interrupt controller outside
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            channelFlagPulse <= 1'b0;
            timerFlagPulse <= 1'b0;
        end else begin
            channelFlagPulse <= fallDual || (faultNow && !fault_q);
            timerFlagPulse <= loadDuty;
        end
    end

    // sticky copies, write one to clear, a new event wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chFlag_q <= 1'b0;
        end else if (channelFlagPulse) begin
            chFlag_q <= 1'b1;
        end else if (wrFlags && pwdata[`OCMP_CHFLAG_BIT]) begin
            chFlag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tmFlag_q <= 1'b0;
        end else if (timerFlagPulse) begin
            tmFlag_q <= 1'b1;
        end else if (wrFlags && pwdata[`OCMP_TMFLAG_BIT]) begin
            tmFlag_q <= 1'b0;
        end
    end

    // read mux, unused upper bits read zero
    always_comb begin
        readData = 32'h0000_0000;
        unique case (paddr)
            `OCMP_CTRL_OFFSET: begin
                readData[`OCMP_MODE_MSB:`OCMP_MODE_LSB] = mode_q;
                readData[`OCMP_TBSEL_BIT] = timeBaseSel_q;
                readData[`OCMP_FAULT_BIT] = fault_q;
            end
            `OCMP_PRI_OFFSET: begin
                readData[15:0] = primary_q;
            end
            `OCMP_SEC_OFFSET: begin
                readData[15:0] = secondary_q;
            end
            `OCMP_FLAGS_OFFSET: begin
                readData[`OCMP_CHFLAG_BIT] = chFlag_q;
                readData[`OCMP_TMFLAG_BIT] = tmFlag_q;
            end
            default: begin
                readData = 32'h0000_0000;
            end
        endcase
    end

    // read data captured in setup, stable through access
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (setupPhase && !pwrite) begin
            prdata <= readData;
        end
    end
endmodule // output_compare_channel

// ===== rtl/ocmp_regs.svh
// Purpose: register offsets, field positions and reset values
// Assumes: APB byte addresses, one aligned 32-bit word per register
// Notes: compare registers are 16 bits wide and sit in the low bits
`ifndef OCMP_REGS_SVH
`define OCMP_REGS_SVH

`define OCMP_CTRL_OFFSET 12'h000
`define OCMP_PRI_OFFSET 12'h004
`define OCMP_SEC_OFFSET 12'h008
`define OCMP_FLAGS_OFFSET 12'h00C

`define OCMP_MODE_LSB 0
`define OCMP_MODE_MSB 2
`define OCMP_TBSEL_BIT 3
`define OCMP_FAULT_BIT 4
`define OCMP_CHFLAG_BIT 0
`define OCMP_TMFLAG_BIT 1

`define OCMP_CTRL_RESET 3'h0
`define OCMP_PRI_RESET 16'h0000
`define OCMP_SEC_RESET 16'h0000

`endif

// ===== rtl/ocmp_pkg.sv
// Purpose: shared types of the compare channel
// Assumes: 16-bit time bases
// Notes: constants live in ocmp_regs.svh
package ocmp_pkg;

    typedef logic [15:0] word_type;

    // one time base as seen by the channel
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] period;
        logic periodMatch;
    } timer_type;

    // compare mode field encodings
    typedef enum logic [2:0] {
        MODE_OFF = 3'b000,
        MODE_R1 = 3'b001,
        MODE_R2 = 3'b010,
        MODE_R3 = 3'b011,
        MODE_R4 = 3'b100,
        MODE_DUAL = 3'b101,
        MODE_PWM = 3'b110,
        MODE_PWM_FLT = 3'b111
    } mode_type;

endpackage

// ===== rtl/bit_sync.sv
// Purpose: two-stage synchroniser for one asynchronous level
// Assumes: input may change at any time
// Notes: first stage is read only by the second
`timescale 1ns/100ps
module bit_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic resetValue,
    input wire logic asyncIn,
    output logic syncOut
);
    logic meta_q;

    // both stages reset to one; the resetValue port is left unused
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b1;
            syncOut <= 1'b1;
        end else begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule // bit_sync

// ===== rtl/time_base_select.sv
// Purpose: picks one of two external time bases
// Assumes: both timers run on clk
// Notes: purely combinational
`timescale 1ns/100ps
module time_base_select (
    input ocmp_pkg::timer_type timerA,
    input ocmp_pkg::timer_type timerB,
    input wire logic selectB,
    output ocmp_pkg::timer_type selected
);
    // same clock domain, so no crossing needed
    assign selected = selectB ? timerB : timerA;
endmodule // time_base_select

// ===== bench/ocmp_assertions.sv
// Purpose: port-level checks of the compare channel
// Assumes: zero-wait APB, both timers on clk
// Notes: shadows mode and compare values off the bus
`timescale 1ns/100ps
`include "ocmp_regs.svh"
module ocmp_assertions (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input ocmp_pkg::timer_type timerA,
    input ocmp_pkg::timer_type timerB,
    input wire logic faultIn_n,
    input wire logic compareOut,
    input wire logic compareOutEn,
    input wire logic channelFlagPulse,
    input wire logic timerFlagPulse
);
    logic [3:0] ctl_q;
    logic [15:0] pri_q;
    logic [15:0] sec_q;
    logic wr;
    logic pwm;
    logic dual;
    ocmp_pkg::timer_type t;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // decode of the bus and the selected time base
    assign wr = psel && penable && pwrite;
    assign pwm = ctl_q[2:1] == 2'b11;
    assign dual = ctl_q[2:0] == 3'b101 && !wr;
    assign t = ctl_q[3] ? timerB : timerA;
    // shadow copy; primary follows the buffer in pwm
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_q <= 4'h0;
            pri_q <= 16'h0000;
            sec_q <= 16'h0000;
        end else begin
            if (wr && paddr == `OCMP_CTRL_OFFSET) ctl_q <= pwdata[3:0];
            if (wr && paddr == `OCMP_SEC_OFFSET) sec_q <= pwdata[15:0];
            if (wr && paddr == `OCMP_PRI_OFFSET && !pwm) begin
                pri_q <= pwdata[15:0];
            end else if (pwm && t.periodMatch) begin
                pri_q <= sec_q;
            end
        end
    end
    dual_rise_a: assert property (dual && $changed(t.count) &&
        t.count == pri_q && pri_q != sec_q && !compareOut |=> compareOut)
        else $error("no rise at primary match");
    dual_fall_a: assert property (dual && $changed(t.count) &&
        t.count == sec_q && pri_q != sec_q && compareOut
        |=> !compareOut && channelFlagPulse)
        else $error("no fall or flag at secondary match");
    primary_beyond_a: assert property (dual && pri_q > t.period &&
        sec_q > t.period && !compareOut |=> !compareOut)
        else $error("output left low level");
    entry_low_a: assert property (wr && paddr == `OCMP_CTRL_OFFSET
        && pwdata[2:0] == 3'b101 |=> !compareOut)
        else $error("dual entry not low");
    pwm_flag_a: assert property (pwm && t.periodMatch
        |=> timerFlagPulse) else $error("timer flag missing");
    pwm_high_a: assert property (pwm && !wr && t.periodMatch &&
        compareOutEn && sec_q != 16'h0000 |=> compareOut)
        else $error("pwm not high at period");
    pwm_low_a: assert property (pwm && !wr && !t.periodMatch &&
        t.count == pri_q |=> !compareOut)
        else $error("pwm not low at duty");
    fault_float_a: assert property (ctl_q[2:0] == 3'b111 &&
        !faultIn_n |-> ##[0:4] !compareOutEn)
        else $error("fault did not float output");
    fault_hold_a: assert property (!compareOutEn && !wr
        |=> !compareOutEn) else $error("float released early");
    cover property (dual && channelFlagPulse);
    cover property (!compareOutEn);
    cover property (pwm && timerFlagPulse);
endmodule // ocmp_assertions

// ===== bench/pin_load_model.sv
// Purpose: load and fault source on the channel pins
// Assumes: pull-down on the output pin
// Notes: fault source is asynchronous to clk
`timescale 1ns/100ps
module pin_load_model (
    input wire logic compareOut,
    input wire logic compareOutEn,
    input wire logic faultReq,
    output logic pinLevel,
    output logic faultIn_n
);
    assign pinLevel = compareOutEn ? compareOut : 1'b0;
    assign faultIn_n = !faultReq;
endmodule // pin_load_model

// ===== bench/test_output_compare_channel.sv
// Purpose: directed test of the compare channel
// Assumes: timers modelled here, zero-wait APB slave
// Notes: timer B runs free so the select path stays driven
`timescale 1ns/100ps
`include "ocmp_regs.svh"
module test_output_compare_channel;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic faultReq = 1'b0;
    logic runA = 1'b0;
    logic [15:0] cntA = 16'h0000;
    logic [15:0] cntB = 16'h0000;
    logic [31:0] prdata;
    logic pready, pslverr, co, coEn, chFl, tmFl, pin, flt_n;
    logic [31:0] rd;
    logic err = 1'b0;
    logic clrA = 1'b0;
    ocmp_pkg::timer_type tA, tB;
    int failures = 0;
    int n_compared = 0;
    always #50 clk = ~clk;
    // timer A stoppable with period 9; a parked timer never matches
    assign tA = '{cntA, 16'h0009, runA && cntA == 16'h0009};
    assign tB = '{cntB, 16'h0004, cntB == 16'h0004};
    // one process owns the timer count; clear takes priority over run
    always @(posedge clk) begin
        if (clrA) cntA <= 16'h0000;
        else if (runA) cntA <= (cntA == 16'h0009) ? 16'h0000 :
            cntA + 16'h0001;
        cntB <= (cntB == 16'h0004) ? 16'h0000 : cntB + 16'h0001;
    end
    output_compare_channel dut (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .timerA(tA),
        .timerB(tB), .faultIn_n(flt_n), .compareOut(co),
        .compareOutEn(coEn), .channelFlagPulse(chFl), .timerFlagPulse(tmFl));
    pin_load_model load (.compareOut(co), .compareOutEn(coEn),
        .faultReq(faultReq), .pinLevel(pin), .faultIn_n(flt_n));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one APB transfer; request held until pready is seen
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] m,
        input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        chk(rd & m, e);
    endtask
    task automatic waitCnt(input logic [15:0] v);
        do @(posedge clk); while (cntA !== v);
        #1;
    endtask
    // channel off, timer parked at zero, flags cleared
    task automatic setup();
        apb(1'b1, `OCMP_CTRL_OFFSET, 32'h00000000);
        runA <= 1'b0;
        clrA <= 1'b1;
        @(posedge clk);
        clrA <= 1'b0;
        apb(1'b1, `OCMP_FLAGS_OFFSET, 32'h00000003);
    endtask
    task automatic dual(input logic [15:0] p, input logic [15:0] s,
        input logic [2:0] e, input logic f);
        setup();
        apb(1'b1, `OCMP_SEC_OFFSET, {16'h0000, s});
        apb(1'b1, `OCMP_PRI_OFFSET, {16'h0000, p});
        apb(1'b1, `OCMP_CTRL_OFFSET, 32'h00000005);
        runA <= 1'b1;
        waitCnt(16'h0003);
        chk(pin, e[2]);
        waitCnt(16'h0001);
        chk(pin, e[1]);
        waitCnt(16'h0005);
        chk(pin, e[0]);
        rdc(`OCMP_FLAGS_OFFSET, 32'h00000001, {31'h0, f});
    endtask
    task automatic end_of_test();
        if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // watchdog: the tests need well under a thousand cycles
    initial begin
        #500000;
        failures++;
        end_of_test();
    end
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rdc(`OCMP_CTRL_OFFSET, 32'hFFFFFFFF, 32'h00000000);
        rdc(`OCMP_SEC_OFFSET, 32'hFFFFFFFF, 32'h00000000);
        apb(1'b0, 12'h010, 32'h00000000);
        chk(err, 1'b1);
        chk({rd[31:1], rd[0]}, 32'h00000000);
        dual(16'h0002, 16'h0004, 3'b100, 1'b1);
        dual(16'h0002, 16'h000C, 3'b111, 1'b0);
        dual(16'h000C, 16'h000E, 3'b000, 1'b0);
        setup();
        apb(1'b1, `OCMP_SEC_OFFSET, 32'h00000006);
        apb(1'b1, `OCMP_PRI_OFFSET, 32'h00000003);
        apb(1'b1, `OCMP_CTRL_OFFSET, 32'h00000006);
        apb(1'b1, `OCMP_PRI_OFFSET, 32'h00000008);
        rdc(`OCMP_PRI_OFFSET, 32'hFFFFFFFF, 32'h00000003);
        runA <= 1'b1;
        waitCnt(16'h0002);
        chk(pin, 1'b1);
        waitCnt(16'h0005);
        chk(pin, 1'b0);
        waitCnt(16'h0002);
        rdc(`OCMP_PRI_OFFSET, 32'hFFFFFFFF, 32'h00000006);
        waitCnt(16'h0008);
        chk(pin, 1'b0);
        rdc(`OCMP_FLAGS_OFFSET, 32'h00000002, 32'h00000002);
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, `OCMP_SEC_OFFSET, i ? 32'h0000000C : 32'h00000000);
            waitCnt(16'h0009);
            waitCnt(16'h0007);
            chk(pin, i[0]);
        end
        faultReq <= 1'b1;
        repeat (4) @(posedge clk);
        chk(coEn, 1'b1);
        apb(1'b1, `OCMP_CTRL_OFFSET, 32'h00000007);
        repeat (4) @(posedge clk);
        chk(pin, 1'b0);
        rdc(`OCMP_CTRL_OFFSET, 32'hFFFFFFFF, 32'h00000017);
        rdc(`OCMP_FLAGS_OFFSET, 32'h00000001, 32'h00000001);
        faultReq <= 1'b0;
        repeat (4) @(posedge clk);
        chk(coEn, 1'b0);
        apb(1'b1, `OCMP_CTRL_OFFSET, 32'h00000007);
        rdc(`OCMP_CTRL_OFFSET, 32'hFFFFFFFF, 32'h00000007);
        chk(coEn, 1'b1);
        end_of_test();
    end
endmodule // test_output_compare_channel
bind output_compare_channel ocmp_assertions chk_i (.clk(clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .timerA(timerA), .timerB(timerB),
    .faultIn_n(faultIn_n), .compareOut(compareOut),
    .compareOutEn(compareOutEn), .channelFlagPulse(channelFlagPulse),
    .timerFlagPulse(timerFlagPulse));
